// >>> hdl/isf_pkg.sv
// Package for the sensor sample buffer: register map, fields, modes, types
package isf_pkg;

   // Register offsets on the plain register port
   localparam logic [6:0] THR_LOW_ADDR = 7'h06;   // buffer_threshold_low_reg
   localparam logic [6:0] THR_HIGH_ADDR = 7'h07;  // buffer_threshold_high_reg
   localparam logic [6:0] DEC12_ADDR = 7'h08;     // decimation_ds1_ds2_reg
   localparam logic [6:0] DEC34_ADDR = 7'h09;     // decimation_ds3_ds4_reg
   localparam logic [6:0] RATE_MODE_ADDR = 7'h0a; // buffer_rate_mode_reg
   localparam logic [6:0] TRIG_SEL_ADDR = 7'h0b;  // data-valid/event select
   localparam logic [6:0] CNT_LOW_ADDR = 7'h3a;   // buffer_count_low_reg
   localparam logic [6:0] CNT_FLAG_ADDR = 7'h3b;  // buffer_count_flags_reg
   localparam logic [6:0] PAT_LOW_ADDR = 7'h3c;   // pattern_index_low_reg
   localparam logic [6:0] PAT_HIGH_ADDR = 7'h3d;  // pattern_index_high_reg
   localparam logic [6:0] OUT_L_ADDR = 7'h3e;
   localparam logic [6:0] OUT_H_ADDR = 7'h3f;

   // Field positions
   localparam int STEP_TRIG_BIT = 7;    // step_trigger_select in thr high
   localparam int HALT_THR_BIT = 7;     // halt_at_threshold in ds3/ds4 reg
   localparam int FULL_BIT = 5;         // smart-full flag in count flags
   localparam int EMPTY_BIT = 4;
   localparam int OVERRUN_BIT = 6;
   localparam int THR_REACHED_BIT = 7;
   localparam int DVALID_SEL_BIT = 0;   // in trigger select reg
   localparam int EVENT_SEL_LSB = 4;    // 3-bit event source in trigger reg

   // Reset values
   localparam logic [7:0] REG_RESET = 8'h00;

   // Buffer mode encodings
   localparam logic [2:0] MODE_BYPASS = 3'h0;
   localparam logic [2:0] MODE_FIFO = 3'h1;
   localparam logic [2:0] MODE_C2F = 3'h3;
   localparam logic [2:0] MODE_B2C = 3'h4;
   localparam logic [2:0] MODE_CONT = 3'h6;

   // Decimation code 0 means the set is not stored
   localparam logic [2:0] DEC_OFF = 3'h0;

   // Operating phase, Gray along idle -> run -> stop
   typedef enum logic [1:0] {
      ISF_IDLE = 2'b00,
      ISF_RUN = 2'b01,
      ISF_STOP = 2'b11
   } isf_phase_t;

   // Sensor event strobes coming into the block
   typedef struct packed {
      logic data_ready;
      logic step;
      logic hub_done;
      logic [7:0] irq;   // candidate event interrupts
   } isf_events_t;

   // Sample words for the four data sets
   typedef struct packed {
      logic [15:0] ds1;
      logic [15:0] ds2;
      logic [15:0] ds3;
      logic [15:0] ds4;
   } isf_samples_t;

endpackage : isf_pkg

// >>> hdl/isf_buffer.sv
// Sample buffer with trigger modes, write source select and decimation
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module isf_buffer
   import isf_pkg::*;
#(
   parameter int DEPTH_LOG2 = 11,
   parameter int WORDS_PER_SET = 3
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Sensor side
   input wire isf_events_t events,
   input wire isf_samples_t samples,
   // Status
   output logic smart_full,
   output logic buf_empty
);

   localparam int DEPTH = 1 << DEPTH_LOG2;
   localparam logic [DEPTH_LOG2:0] FULL_CNT = DEPTH[DEPTH_LOG2:0];
   localparam logic [DEPTH_LOG2:0] SET_W = WORDS_PER_SET[DEPTH_LOG2:0];

   // Configuration registers
   logic [7:0] thr_low_r, thr_high_r, dec12_r, dec34_r, rate_mode_r, trig_sel_r;

   // Buffer storage and pointers
   logic [15:0] mem [DEPTH];
   logic [DEPTH_LOG2-1:0] wptr_r;
   logic [DEPTH_LOG2-1:0] rptr_r;
   logic [DEPTH_LOG2:0] count_r;
   logic overrun_r;
   logic [9:0] pat_r;
   logic [9:0] pat_len_r;
   logic [9:0] wpat_r;
   logic out_hi_r;
   logic [7:0] out_hi_latch_r;
   isf_phase_t phase_r;
   logic armed_r;

   // Write sequencing: a set is 0..4 data sets of WORDS_PER_SET words
   logic [3:0] set_mask_r;
   logic [1:0] cur_ds_r;
   logic [1:0] word_r;
   logic busy_r;
   logic [4:0] dec_cnt_r [4];  // Wide enough for the divide-by-20 code
   logic [3:0] trig_cnt_r;

   // Event synchroniser and edge detect
   logic [7:0] irq_s1_r;
   logic [7:0] irq_s2_r;
   logic sel_irq_d_r;

   logic [2:0] mode;
   logic [10:0] thr;
   logic halt_thr, sel_irq, irq_rise, wr_trig, do_write, do_pop;
   logic [11:0] limit;
   logic [11:0] cnt_wide;
   logic [DEPTH_LOG2:0] set_words;
   logic full_next, at_full;

   // Decimation code to divider; zero means the set is skipped
   function automatic logic [4:0] dec_div(input logic [2:0] code);
      case (code)
         3'h1: dec_div = 5'h01;
         3'h2: dec_div = 5'h02;
         3'h3: dec_div = 5'h03;
         3'h4: dec_div = 5'h04;
         3'h5: dec_div = 5'h08;
         3'h6: dec_div = 5'h10;
         3'h7: dec_div = 5'h14;
         default: dec_div = 5'h00;
      endcase
   endfunction : dec_div

   // Field extraction
   assign mode = rate_mode_r[2:0];
   assign thr = {thr_high_r[2:0], thr_low_r};
   assign halt_thr = dec34_r[HALT_THR_BIT];
   assign sel_irq = irq_s2_r[trig_sel_r[EVENT_SEL_LSB +: 3]];
   assign cnt_wide = 12'(count_r);  // Count seen at the 12-bit limit width
   assign irq_rise = sel_irq & ~sel_irq_d_r;

   // Write trigger source select
   always_comb begin
      if (trig_sel_r[DVALID_SEL_BIT])
         wr_trig = events.hub_done;
      else if (thr_high_r[STEP_TRIG_BIT])
         wr_trig = events.step;
      else
         wr_trig = events.data_ready;
   end

   // Words in the set chosen at the last trigger, from set_mask_r
   always_comb begin
      set_words = '0;
      for (int i = 0; i < 4; i++) begin
         if (set_mask_r[i])
            set_words = set_words + SET_W;
      end
   end

   // Smart-full limit, optionally capped at the threshold
   assign limit = halt_thr ? {1'b0, thr} : 12'(FULL_CNT);
   assign full_next = (cnt_wide + 12'(set_words)) >= limit;
   assign at_full = cnt_wide >= limit;

   assign do_pop = reg_rd && (reg_addr == OUT_H_ADDR) && count_r != '0
                   && mode != MODE_BYPASS;
   assign do_write = busy_r && phase_r == ISF_RUN;

   // Event input synchroniser
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_s1_r <= '0;
         irq_s2_r <= '0;
         sel_irq_d_r <= 1'b0;
      end else begin
         irq_s1_r <= events.irq;
         irq_s2_r <= irq_s1_r;
         sel_irq_d_r <= sel_irq;
      end
   end

   // Register writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         thr_low_r <= REG_RESET;
         thr_high_r <= REG_RESET;
         dec12_r <= REG_RESET;
         dec34_r <= REG_RESET;
         rate_mode_r <= REG_RESET;
         trig_sel_r <= REG_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            THR_LOW_ADDR: thr_low_r <= reg_wdata;
            THR_HIGH_ADDR: thr_high_r <= reg_wdata;
            DEC12_ADDR: dec12_r <= reg_wdata;
            DEC34_ADDR: dec34_r <= reg_wdata;
            RATE_MODE_ADDR: rate_mode_r <= reg_wdata;
            TRIG_SEL_ADDR: trig_sel_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Mode phase: idle in bypass, run, stop when full in FIFO and C2F (in C2F only after the event)
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         phase_r <= ISF_IDLE;
         armed_r <= 1'b0;
      end else begin
         case (mode)
            MODE_BYPASS: begin
               phase_r <= ISF_IDLE;
               armed_r <= 1'b0;
            end
            MODE_C2F: begin
               if (irq_rise)
                  armed_r <= 1'b1;
               if (phase_r == ISF_IDLE)
                  phase_r <= ISF_RUN;
               else if (phase_r == ISF_RUN && (armed_r || irq_rise)
                        && full_next && !busy_r && wr_trig)
                  phase_r <= ISF_STOP;
            end
            MODE_B2C: begin
               if (phase_r == ISF_IDLE && irq_rise)
                  phase_r <= ISF_RUN;
               else if (phase_r == ISF_STOP)
                  phase_r <= ISF_RUN;
            end
            MODE_FIFO: begin
               if (phase_r == ISF_IDLE)
                  phase_r <= ISF_RUN;
               else if (full_next && !busy_r)
                  phase_r <= ISF_STOP;
            end
            MODE_CONT: begin
               if (phase_r != ISF_RUN)
                  phase_r <= ISF_RUN;
            end
            default: phase_r <= ISF_IDLE;
         endcase
      end
   end

   // Decimation counters choose which sets join each trigger
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         set_mask_r <= '0;
         busy_r <= 1'b0;
         cur_ds_r <= '0;
         word_r <= '0;
         trig_cnt_r <= '0;
         for (int i = 0; i < 4; i++)
            dec_cnt_r[i] <= '0;
      end else if (phase_r != ISF_RUN) begin
         busy_r <= 1'b0;
         set_mask_r <= '0;
         trig_cnt_r <= '0;
         for (int i = 0; i < 4; i++)
            dec_cnt_r[i] <= '0;
      end else if (!busy_r && wr_trig) begin
         for (int i = 0; i < 4; i++) begin
            logic [2:0] code;
            code = (i == 0) ? dec12_r[2:0] : (i == 1) ? dec12_r[5:3] :
                   (i == 2) ? dec34_r[2:0] : dec34_r[5:3];
            set_mask_r[i] <= code != DEC_OFF && dec_cnt_r[i] == 5'h00;
            if (code == DEC_OFF || dec_cnt_r[i] + 5'h01 >= dec_div(code))
               dec_cnt_r[i] <= 5'h00;
            else
               dec_cnt_r[i] <= dec_cnt_r[i] + 5'h01;
         end
         busy_r <= dec12_r[5:0] != '0 || dec34_r[5:0] != '0;
         cur_ds_r <= '0;
         word_r <= '0;
         trig_cnt_r <= trig_cnt_r + 4'h1;
      end else if (busy_r) begin
         if (!set_mask_r[cur_ds_r] ||
             word_r == 2'(WORDS_PER_SET - 1)) begin
            word_r <= '0;
            cur_ds_r <= cur_ds_r + 2'h1;
            if (cur_ds_r == 2'h3)
               busy_r <= 1'b0;
         end else
            word_r <= word_r + 2'h1;
      end
   end

   // Sample storage
   always_ff @(posedge mclk) begin
      if (do_write && set_mask_r[cur_ds_r]) begin
         case (cur_ds_r)
            2'h0: mem[wptr_r] <= samples.ds1;
            2'h1: mem[wptr_r] <= samples.ds2;
            2'h2: mem[wptr_r] <= samples.ds3;
            default: mem[wptr_r] <= samples.ds4;
         endcase
      end
   end

   // Pointers, count, overrun and pattern index
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
         overrun_r <= 1'b0;
         pat_r <= '0;
         wpat_r <= '0;
         pat_len_r <= '0;
      end else if (phase_r == ISF_IDLE || mode == MODE_BYPASS) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
         overrun_r <= 1'b0;
         pat_r <= '0;
         wpat_r <= '0;
         pat_len_r <= '0;
      end else begin
         logic wr;
         logic ovw;
         wr = do_write && set_mask_r[cur_ds_r];
         ovw = wr && count_r == FULL_CNT;
         if (wr)
            wptr_r <= wptr_r + 1'b1;
         if (ovw) begin
            rptr_r <= rptr_r + 1'b1;
            overrun_r <= 1'b1;
         end else if (do_pop)
            rptr_r <= rptr_r + 1'b1;
         if (wr && !ovw && !do_pop)
            count_r <= count_r + 1'b1;
         else if (!wr && do_pop)
            count_r <= count_r - 1'b1;
         if (wr)
            wpat_r <= wpat_r + 10'h1;
         if (!busy_r && wr_trig && trig_cnt_r == 4'h1 && wpat_r != '0)
            pat_len_r <= wpat_r;
         if (ovw || do_pop)
            pat_r <= (pat_len_r != '0 && pat_r + 10'h1 >= pat_len_r) ?
                     10'h0 : pat_r + 10'h1;
      end
   end

   // Read data: low byte latches the word so the high byte matches it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
         out_hi_r <= 1'b0;
         out_hi_latch_r <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            THR_LOW_ADDR: reg_rdata <= thr_low_r;
            THR_HIGH_ADDR: reg_rdata <= thr_high_r;
            DEC12_ADDR: reg_rdata <= dec12_r;
            DEC34_ADDR: reg_rdata <= dec34_r;
            RATE_MODE_ADDR: reg_rdata <= rate_mode_r;
            TRIG_SEL_ADDR: reg_rdata <= trig_sel_r;
            CNT_LOW_ADDR: reg_rdata <= cnt_wide[7:0];
            CNT_FLAG_ADDR: reg_rdata <= {at_full && cnt_wide >= {1'b0, thr},
               overrun_r, full_next && phase_r != ISF_IDLE, cnt_wide == '0,
               1'b0, cnt_wide[10:8]};
            PAT_LOW_ADDR: reg_rdata <= pat_r[7:0];
            PAT_HIGH_ADDR: reg_rdata <= {6'h00, pat_r[9:8]};
            OUT_L_ADDR: begin
               reg_rdata <= mem[rptr_r][7:0];
               out_hi_latch_r <= mem[rptr_r][15:8];
               out_hi_r <= 1'b1;
            end
            OUT_H_ADDR: begin
               reg_rdata <= out_hi_r ? out_hi_latch_r : mem[rptr_r][15:8];
               out_hi_r <= 1'b0;
            end
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Status outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         smart_full <= 1'b0;
         buf_empty <= 1'b1;
      end else begin
         smart_full <= full_next && phase_r != ISF_IDLE;
         buf_empty <= count_r == '0;
      end
   end

endmodule : isf_buffer

// >>> test/isf_sensor_model.sv
// Sensor-side model: trigger strobes, sample words, event lines
`timescale 1ns/1ps
module isf_sensor_model
   import isf_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Requests from the bench
   input wire logic fire,
   input wire logic [1:0] kind,
   input wire logic irq_on,
   input wire logic [2:0] irq_idx,
   // Towards the buffer
   output wire isf_events_t events,
   output wire isf_samples_t samples
);
   logic [7:0] n_r;
   logic go_r;
   // New sample words and the strobe appear in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         n_r <= 8'h00;
         go_r <= 1'b0;
      end else begin
         go_r <= fire;
         if (fire) n_r <= n_r + 8'h01;
      end
   end
   // Words stay put while a set is written
   assign samples = {8'h11, n_r, 8'h22, n_r, 8'h33, n_r, 8'h44, n_r};
   assign events.data_ready = go_r && kind == 2'h0;
   assign events.step = go_r && kind == 2'h1;
   assign events.hub_done = go_r && kind == 2'h2;
   // Only the one chosen source ever rises
   assign events.irq = irq_on ? 8'h01 << irq_idx : 8'h00;
endmodule : isf_sensor_model

// >>> test/isf_buffer_chk.sv
// Port-level checker for the sample buffer
`timescale 1ns/1ps
module isf_buffer_chk
   import isf_pkg::*;
#(
   parameter int DEPTH_LOG2 = 11,
   parameter int WORDS_PER_SET = 3
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Sensor side and status
   input wire isf_events_t events,
   input wire logic smart_full,
   input wire logic buf_empty
);
   logic [2:0] mode_r;
   logic [2:0] dec1_r;
   logic step_r;
   logic hub_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Shadow of the host's configuration writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_r <= 3'h0;
         dec1_r <= 3'h0;
         step_r <= 1'b0;
         hub_r <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == RATE_MODE_ADDR) mode_r <= reg_wdata[2:0];
         if (reg_addr == DEC12_ADDR) dec1_r <= reg_wdata[2:0];
         if (reg_addr == THR_HIGH_ADDR) step_r <= reg_wdata[STEP_TRIG_BIT];
         if (reg_addr == TRIG_SEL_ADDR) hub_r <= reg_wdata[DVALID_SEL_BIT];
      end
   end
   property p_unmap;
      reg_rd && reg_addr == 7'h7f |=> reg_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   property p_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved");
   property p_flags;
      reg_rd && reg_addr == CNT_FLAG_ADDR |=>
         reg_rdata[EMPTY_BIT] == buf_empty &&
         reg_rdata[FULL_BIT] == smart_full;
   endproperty
   a_flags: assert property (p_flags)
      else $error("status flags differ from pins");
   property p_cnt0;
      reg_rd && reg_addr == CNT_LOW_ADDR ##1 buf_empty |-> reg_rdata == 8'h00;
   endproperty
   a_cnt0: assert property (p_cnt0)
      else $error("count not zero when empty");
   property p_bpclr;
      reg_wr && reg_addr == RATE_MODE_ADDR && reg_wdata[2:0] == MODE_BYPASS
         |-> ##[1:3] buf_empty;
   endproperty
   a_bpclr: assert property (p_bpclr)
      else $error("bypass did not clear");
   property p_bpstay;
      mode_r == MODE_BYPASS && buf_empty |=> buf_empty;
   endproperty
   a_bpstay: assert property (p_bpstay)
      else $error("bypass stored data");
   property p_dr;
      mode_r == MODE_CONT && dec1_r == 3'h1 && !step_r && !hub_r &&
         events.data_ready |-> ##[1:4] !buf_empty;
   endproperty
   a_dr: assert property (p_dr)
      else $error("data-ready did not store");
   property p_step;
      (step_r && !hub_r && !events.step && buf_empty) [*6] |=> buf_empty;
   endproperty
   a_step: assert property (p_step)
      else $error("stored without a step");
   property p_hub;
      (hub_r && !events.hub_done && buf_empty) [*6] |=> buf_empty;
   endproperty
   a_hub: assert property (p_hub)
      else $error("stored without hub completion");
endmodule : isf_buffer_chk

// >>> test/tb_top.sv
// Bench for the sample buffer: register tasks and mode scenarios
`timescale 1ns/1ps
module tb_top
   import isf_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic smart_full;
   logic buf_empty;
   logic fire = 1'b0;
   logic [1:0] kind = 2'h0;
   logic irq_on = 1'b0;
   isf_events_t events;
   isf_samples_t samples;
   int bad_count = 0;
   int num_checks = 0;
   logic [7:0] n = 8'h00;
   logic [7:0] d;
   logic [15:0] w;
   always #10 mclk = ~mclk;
   isf_buffer #(.DEPTH_LOG2(5), .WORDS_PER_SET(3)) u_dut (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .events(events), .samples(samples), .smart_full(smart_full),
      .buf_empty(buf_empty));
   isf_sensor_model u_sens (.mclk(mclk), .rst(rst), .fire(fire),
      .kind(kind), .irq_on(irq_on), .irq_idx(3'h2), .events(events),
      .samples(samples));
   task automatic chk(input string nm, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   // Data appear in the cycle after the strobe and hold until the next read
   task automatic rd(input logic [6:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic setm(input logic [2:0] m);
      wr(RATE_MODE_ADDR, {5'h00, m});
   endtask : setm
   // Low byte first; the high read releases the word
   task automatic pop();
      rd(OUT_L_ADDR);
      w[7:0] = d;
      rd(OUT_H_ADDR);
      w[15:8] = d;
   endtask : pop
   task automatic stat(input logic [10:0] c);
      logic [7:0] lo;
      rd(CNT_LOW_ADDR);
      lo = d;
      rd(CNT_FLAG_ADDR);
      chk("count", {5'h00, c}, {5'h00, d[2:0], lo});
      chk("empty flag", {15'h0000, c == 11'h000}, {15'h0000, d[EMPTY_BIT]});
      chk("empty pin", {15'h0000, c == 11'h000}, {15'h0000, buf_empty});
   endtask : stat
   // One strobe, then time for a whole set to land
   task automatic trig(input logic [1:0] k);
      @(posedge mclk);
      kind <= k;
      fire <= 1'b1;
      n = n + 8'h01;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (16) @(posedge mclk);
   endtask : trig
   task automatic pulse_irq();
      @(posedge mclk);
      irq_on <= 1'b1;
      repeat (6) @(posedge mclk);
      irq_on <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : pulse_irq
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      // Reset state, unmapped place, bypass ignores triggers
      rd(7'h7f);
      chk("unmapped", 16'h0000, {8'h00, d});
      rd(RATE_MODE_ADDR);
      chk("mode", 16'h0000, {8'h00, d});
      wr(DEC12_ADDR, 8'h01);
      wr(TRIG_SEL_ADDR, 8'h20);
      trig(2'h0);
      stat(11'h000);
      // Idle until the event edge, then runs on after it drops
      setm(MODE_B2C);
      trig(2'h0);
      stat(11'h000);
      pulse_irq();
      trig(2'h0);
      stat(11'h003);
      trig(2'h0);
      stat(11'h006);
      rd(PAT_LOW_ADDR);
      chk("pattern", 16'h0000, {8'h00, d});
      pop();
      chk("word", {8'h11, n - 8'h01}, w);
      rd(PAT_LOW_ADDR);
      chk("pattern", 16'h0001, {8'h00, d});
      for (int i = 1; i < 6; i++) begin
         pop();
         chk("word", {8'h11, n - 8'h01 + 8'(i / 3)}, w);
         // Index wraps every three words of the one-set pattern
         if (i == 4) begin
            rd(PAT_LOW_ADDR);
            chk("pattern", 16'h0002, {8'h00, d});
         end
      end
      stat(11'h000);
      trig(2'h0);
      stat(11'h003);
      setm(MODE_BYPASS);
      stat(11'h000);
      // Second set kept every other trigger
      wr(DEC12_ADDR, 8'h11);
      setm(MODE_CONT);
      trig(2'h0);
      stat(11'h006);
      trig(2'h0);
      stat(11'h009);
      for (int i = 0; i < 6; i++) begin
         pop();
         chk("set order", {(i < 3) ? 8'h11 : 8'h22, n - 8'h01}, w);
      end
      setm(MODE_BYPASS);
      // Step pacing, then hub pacing over the step bit
      wr(DEC12_ADDR, 8'h01);
      wr(THR_HIGH_ADDR, 8'h80);
      for (int j = 0; j < 2; j++) begin
         wr(TRIG_SEL_ADDR, (j == 0) ? 8'h20 : 8'h21);
         setm(MODE_CONT);
         trig(2'(j));
         stat(11'h000);
         trig(2'(j + 1));
         stat(11'h003);
         setm(MODE_BYPASS);
      end
      // Depth held to the threshold; stops once smart-full
      wr(TRIG_SEL_ADDR, 8'h20);
      wr(THR_HIGH_ADDR, 8'h00);
      wr(THR_LOW_ADDR, 8'h06);
      wr(DEC34_ADDR, 8'h80);
      setm(MODE_C2F);
      pulse_irq();
      trig(2'h0);
      stat(11'h003);
      chk("smart full", 16'h0001, {15'h0000, smart_full});
      trig(2'h0);
      stat(11'h003);
      setm(MODE_BYPASS);
      wr(DEC34_ADDR, 8'h00);
      conclude();
   end
   // Cut a hang short well past the run length
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      conclude();
   end
endmodule : tb_top
bind isf_buffer isf_buffer_chk #(.DEPTH_LOG2(DEPTH_LOG2),
   .WORDS_PER_SET(WORDS_PER_SET)) u_chk (.mclk(mclk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events),
   .smart_full(smart_full), .buf_empty(buf_empty));
